// ==== rtl/fill_ecc_params.svh ====
// Register offsets, field positions and reset values of the fill ECC error block
`ifndef FILL_ECC_PARAMS_SVH
`define FILL_ECC_PARAMS_SVH

`define FER_OFS_ERR_STATUS 8'h00
`define FER_OFS_ADDR_LO 8'h04
`define FER_OFS_ADDR_HI 8'h08
`define FER_OFS_SYNDROME 8'h0C
`define FER_OFS_DC_STATUS 8'h10
`define FER_OFS_INT_STATUS 8'h14
`define FER_OFS_INT_CLEAR 8'h18
`define FER_OFS_INT_ENABLE 8'h1C

`define FER_BIT_CRD 0
`define FER_BIT_MACHINE_CHECK 1
`define FER_BIT_LOAD_ECC 0

`define FER_INT_ENABLE_RST 2'h0
`define FER_ADDR_W 37
`define FER_ADDR_HI_W 5

`define FER_RESP_OKAY 2'h0
`define FER_RESP_SLVERR 2'h2

`endif

// ==== rtl/fill_ecc_pkg.sv ====
// Types shared by the fill ECC error block and its users
package fill_ecc_pkg;

  // Source of a single-bit error reported by the checkers
  typedef enum logic [2:0] {
    EV_IFILL = 3'h0,
    EV_DFILL = 3'h1,
    EV_VICTIM_MISS = 3'h2,
    EV_VICTIM_EVICT = 3'h3,
    EV_PROBE = 3'h4
  } event_kind_type;

  // Encoded error type held in the error status register
  typedef enum logic [2:0] {
    CODE_NONE = 3'h0,
    CODE_IFILL_BOARD_CACHE_ERROR = 3'h1,
    CODE_IFILL_MEMORY_ERROR = 3'h2,
    CODE_DFILL_BOARD_CACHE_ERROR = 3'h3,
    CODE_DFILL_MEMORY_ERROR = 3'h4,
    CODE_PROBE_BOARD_CACHE_ERROR = 3'h5
  } status_code_type;

  // One error report from the load_store_data_path checkers
  typedef struct packed {
    logic valid;
    event_kind_type kind;
    logic from_memory;
    logic load_use;
    logic speculative;
    logic [36:0] addr;
    logic [7:0] syndrome0;
    logic [7:0] syndrome1;
  } fill_event_type;

  // Recovery sequencer states
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_REPLAY = 4'b0010,
    ST_SCRUB = 4'b0100,
    ST_RETRY = 4'b1000
  } recover_state_type;

endpackage

// ==== rtl/fill_ecc_error_recovery.sv ====
// Single-bit fill, victim and probe ECC error recovery with an AXI4-Lite register slave
//
// What this block does
// - Icache fill error: bad parity on octaword
// - Board-cache ifill: flush icache, code, address
// - Memory ifill: bad parity, flush, code, address
// - Logged errors load both syndrome registers
// - Ifill error posts and takes machine check
// - Ifill error also posts corrected-read; firmware clears
// - Unused dfill quadword written raw, logged
// - Load-used error: load queue keeps state
// - Replay trap, stall map stage until corrected
// - Error read scrubs block through victim buffer
// - Load-used dfill sets source code, address
// - Retry load, set load ECC flag, post
// - Speculative load: event only, no scrub/status
// - Victim forwarded uncorrected, event, no logging
// - Victim on double miss: event, nothing latched
// - Victim during evict block: forwarded, no event, no logging
// - Probe hit: forward uncorrected, log, event
// - Probe: probe code, address, syndromes, event
//
// Local design decisions: register access over AXI4-Lite and the address map.
`timescale 1ns/10ps
`include "fill_ecc_params.svh"

module fill_ecc_error_recovery (
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  // Error reports and recovery handshakes from the cache fabric
  input wire fill_ecc_pkg::fill_event_type i_event,
  input wire logic i_scrub_done,
  input wire logic i_retry_done,
  // Cache fabric controls
  output logic o_icache_bad_parity,
  output logic o_icache_flush,
  output logic o_dcache_write_raw,
  output logic o_victim_forward,
  output logic o_probe_forward,
  output logic o_load_hold,
  output logic o_replay_trap,
  output logic o_map_stall,
  output logic o_scrub_req,
  output logic o_load_retry,
  output logic o_machine_check_take,
  output logic o_machine_check,
  output logic o_irq,
  // AXI4-Lite slave
  input wire logic [7:0] i_awaddr,
  input wire logic i_awvalid,
  output logic o_awready,
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  input wire logic i_wvalid,
  output logic o_wready,
  output logic [1:0] o_bresp,
  output logic o_bvalid,
  input wire logic i_bready,
  input wire logic [7:0] i_araddr,
  input wire logic i_arvalid,
  output logic o_arready,
  output logic [31:0] o_rdata,
  output logic [1:0] o_rresp,
  output logic o_rvalid,
  input wire logic i_rready
);

  logic [1:0] rst_sync_reg;
  logic rst_n;
  fill_ecc_pkg::recover_state_type state_reg;
  fill_ecc_pkg::status_code_type code_reg;
  logic [36:0] addr_reg;
  logic [7:0] synd0_reg;
  logic [7:0] synd1_reg;
  logic load_ecc_reg;
  logic [1:0] int_status_reg;
  logic [1:0] int_enable_reg;
  logic [7:0] aw_addr_reg;
  logic [31:0] w_data_reg;
  logic aw_got_reg;
  logic w_got_reg;
  logic wstrb0_reg;
  logic wr_fire;
  logic ev_log;
  logic ev_crd;
  logic ev_machine_check;
  logic ev_recover;
  logic ev_ifill;
  fill_ecc_pkg::status_code_type ev_code;

  // Reset release through two flops so that removal is clean
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rst_sync_reg <= 2'h0;
    end else begin
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_reg[1];

  // Register read decode of the live registers, unmapped offsets return zero
  function automatic logic [31:0] reg_read(input logic [7:0] a);
    logic [31:0] d;
    d = 32'h0000_0000;
    unique case (a)
      `FER_OFS_ERR_STATUS: d = {29'h0, code_reg};
      `FER_OFS_ADDR_LO: d = addr_reg[31:0];
      `FER_OFS_ADDR_HI: d = {27'h0, addr_reg[36:32]};
      `FER_OFS_SYNDROME: d = {16'h0, synd1_reg, synd0_reg};
      `FER_OFS_DC_STATUS: d = {31'h0, load_ecc_reg};
      `FER_OFS_INT_STATUS: d = {30'h0, int_status_reg};
      `FER_OFS_INT_ENABLE: d = {30'h0, int_enable_reg};
      default: d = 32'h0000_0000;
    endcase
    return d;
  endfunction

  // Aligned offsets up to the enable register answer OKAY, the write-only clear included
  function automatic logic reg_mapped(input logic [7:0] a);
    return a <= `FER_OFS_INT_ENABLE;
  endfunction

  // Classify each error report into logging and posting actions
  always_comb begin
    ev_log = 1'b0;
    ev_crd = 1'b0;
    ev_machine_check = 1'b0;
    ev_recover = 1'b0;
    ev_ifill = 1'b0;
    ev_code = fill_ecc_pkg::CODE_NONE;
    if (i_event.valid) begin
      unique case (i_event.kind)
        fill_ecc_pkg::EV_IFILL: begin
          ev_ifill = 1'b1;
          ev_log = 1'b1;
          ev_machine_check = 1'b1;
          ev_crd = 1'b1;
          ev_code = i_event.from_memory ? fill_ecc_pkg::CODE_IFILL_MEMORY_ERROR
                                        : fill_ecc_pkg::CODE_IFILL_BOARD_CACHE_ERROR;
        end
        fill_ecc_pkg::EV_DFILL: begin
          ev_crd = 1'b1;
          // A speculative load leaves status and address untouched
          ev_log = !(i_event.load_use && i_event.speculative);
          ev_recover = i_event.load_use && !i_event.speculative;
          ev_code = i_event.from_memory ? fill_ecc_pkg::CODE_DFILL_MEMORY_ERROR
                                        : fill_ecc_pkg::CODE_DFILL_BOARD_CACHE_ERROR;
        end
        fill_ecc_pkg::EV_VICTIM_MISS: begin
          ev_crd = 1'b1;
        end
        fill_ecc_pkg::EV_VICTIM_EVICT: begin
          ev_crd = 1'b0;
        end
        fill_ecc_pkg::EV_PROBE: begin
          ev_log = 1'b1;
          ev_crd = 1'b1;
          ev_code = fill_ecc_pkg::CODE_PROBE_BOARD_CACHE_ERROR;
        end
        default: begin
          ev_crd = 1'b0;
        end
      endcase
    end
  end

  // Write channel completes when both address and data are held
  assign wr_fire = aw_got_reg && w_got_reg && !o_bvalid;

  // Error log: one code at a time, a new error overwrites, an event beats a clear
  always_ff @(posedge i_clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      code_reg <= fill_ecc_pkg::CODE_NONE;
      addr_reg <= 37'h0;
      synd0_reg <= 8'h00;
      synd1_reg <= 8'h00;
    end else if (ev_log) begin
      code_reg <= ev_code;
      addr_reg <= i_event.addr;
      synd0_reg <= i_event.syndrome0;
      synd1_reg <= i_event.syndrome1;
    end else if (wr_fire && aw_addr_reg == `FER_OFS_ERR_STATUS) begin
      code_reg <= fill_ecc_pkg::CODE_NONE;
    end
  end

  // Data cache load ECC flag, set on a scrubbed retry, write one to clear
  always_ff @(posedge i_clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      load_ecc_reg <= 1'b0;
    end else if (state_reg == fill_ecc_pkg::ST_RETRY && i_retry_done) begin
      load_ecc_reg <= 1'b1;
    end else if (wr_fire && aw_addr_reg == `FER_OFS_DC_STATUS &&
                 w_data_reg[`FER_BIT_LOAD_ECC]) begin
      load_ecc_reg <= 1'b0;
    end
  end

  // Sticky event bits; set wins over a clear in the same cycle
  always_ff @(posedge i_clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      int_status_reg <= 2'h0;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if ((i == `FER_BIT_CRD && (ev_crd || (state_reg == fill_ecc_pkg::ST_RETRY &&
             i_retry_done))) || (i == `FER_BIT_MACHINE_CHECK && ev_machine_check)) begin
          int_status_reg[i] <= 1'b1;
        end else if (wr_fire && aw_addr_reg == `FER_OFS_INT_CLEAR && w_data_reg[i]) begin
          int_status_reg[i] <= 1'b0;
        end
      end
    end
  end

  // Enable register gates corrected-read and machine check separately
  always_ff @(posedge i_clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      int_enable_reg <= `FER_INT_ENABLE_RST;
    end else if (wr_fire && aw_addr_reg == `FER_OFS_INT_ENABLE && wstrb0_reg) begin
      int_enable_reg <= w_data_reg[1:0];
    end
  end

  // Interrupt and machine check outputs, registered so they come from flops
  always_ff @(posedge i_clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      o_irq <= 1'b0;
      o_machine_check <= 1'b0;
    end else begin
      o_irq <= |(int_status_reg & int_enable_reg);
      o_machine_check <= int_status_reg[`FER_BIT_MACHINE_CHECK] && int_enable_reg[`FER_BIT_MACHINE_CHECK];
    end
  end

  // Immediate fabric actions, one-cycle pulses
  always_ff @(posedge i_clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      o_icache_bad_parity <= 1'b0;
      o_icache_flush <= 1'b0;
      o_dcache_write_raw <= 1'b0;
      o_victim_forward <= 1'b0;
      o_probe_forward <= 1'b0;
      o_machine_check_take <= 1'b0;
    end else begin
      o_icache_bad_parity <= ev_ifill;
      o_icache_flush <= ev_ifill;
      // Machine check is taken at once, but only while its enable bit is set
      o_machine_check_take <= ev_machine_check && int_enable_reg[`FER_BIT_MACHINE_CHECK];
      o_dcache_write_raw <= i_event.valid && i_event.kind == fill_ecc_pkg::EV_DFILL &&
                            !i_event.load_use;
      o_victim_forward <= i_event.valid && (i_event.kind == fill_ecc_pkg::EV_VICTIM_MISS ||
                          i_event.kind == fill_ecc_pkg::EV_VICTIM_EVICT);
      o_probe_forward <= i_event.valid && i_event.kind == fill_ecc_pkg::EV_PROBE;
    end
  end

  // Recovery sequencer for a load that consumed bad data
  // A second load-use error during recovery is logged and posts corrected-read but starts no replay; the queue retries it later
  always_ff @(posedge i_clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= fill_ecc_pkg::ST_IDLE;
    end else begin
      unique case (state_reg)
        fill_ecc_pkg::ST_IDLE: begin
          if (ev_recover) begin
            state_reg <= fill_ecc_pkg::ST_REPLAY;
          end
        end
        fill_ecc_pkg::ST_REPLAY: begin
          state_reg <= fill_ecc_pkg::ST_SCRUB;
        end
        fill_ecc_pkg::ST_SCRUB: begin
          if (i_scrub_done) begin
            state_reg <= fill_ecc_pkg::ST_RETRY;
          end
        end
        fill_ecc_pkg::ST_RETRY: begin
          if (i_retry_done) begin
            state_reg <= fill_ecc_pkg::ST_IDLE;
          end
        end
        default: begin
          state_reg <= fill_ecc_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // Sequencer outputs, registered from the next state
  always_ff @(posedge i_clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      o_replay_trap <= 1'b0;
      o_map_stall <= 1'b0;
      o_load_hold <= 1'b0;
      o_scrub_req <= 1'b0;
      o_load_retry <= 1'b0;
    end else begin
      o_replay_trap <= state_reg == fill_ecc_pkg::ST_IDLE && ev_recover;
      // Stall and hold stay up until the retried load has rewritten its register
      o_map_stall <= (state_reg == fill_ecc_pkg::ST_IDLE && ev_recover) ||
                     (state_reg != fill_ecc_pkg::ST_IDLE &&
                      !(state_reg == fill_ecc_pkg::ST_RETRY && i_retry_done));
      o_load_hold <= (state_reg == fill_ecc_pkg::ST_IDLE && ev_recover) ||
                     (state_reg != fill_ecc_pkg::ST_IDLE &&
                      !(state_reg == fill_ecc_pkg::ST_RETRY && i_retry_done));
      o_scrub_req <= state_reg == fill_ecc_pkg::ST_REPLAY ||
                     (state_reg == fill_ecc_pkg::ST_SCRUB && !i_scrub_done);
      o_load_retry <= (state_reg == fill_ecc_pkg::ST_SCRUB && i_scrub_done) ||
                      (state_reg == fill_ecc_pkg::ST_RETRY && !i_retry_done);
    end
  end

  // AXI write address and data are taken in either order, held until the response
  always_ff @(posedge i_clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      aw_got_reg <= 1'b0;
      w_got_reg <= 1'b0;
      aw_addr_reg <= 8'h00;
      w_data_reg <= 32'h0000_0000;
      wstrb0_reg <= 1'b0;
      o_awready <= 1'b0;
      o_wready <= 1'b0;
      o_bvalid <= 1'b0;
      o_bresp <= `FER_RESP_OKAY;
    end else begin
      if (i_awvalid && o_awready) begin
        aw_got_reg <= 1'b1;
        aw_addr_reg <= {i_awaddr[7:2], 2'h0};
      end
      if (i_wvalid && o_wready) begin
        w_got_reg <= 1'b1;
        w_data_reg <= i_wdata;
        wstrb0_reg <= i_wstrb[0];
      end
      o_awready <= !aw_got_reg && !(i_awvalid && o_awready);
      o_wready <= !w_got_reg && !(i_wvalid && o_wready);
      if (wr_fire) begin
        o_bvalid <= 1'b1;
        o_bresp <= reg_mapped(aw_addr_reg) ? `FER_RESP_OKAY : `FER_RESP_SLVERR;
      end else if (o_bvalid && i_bready) begin
        o_bvalid <= 1'b0;
        aw_got_reg <= 1'b0;
        w_got_reg <= 1'b0;
        o_awready <= 1'b1;
        o_wready <= 1'b1;
      end
    end
  end

  // AXI read: one cycle from address acceptance to data
  always_ff @(posedge i_clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      o_arready <= 1'b0;
      o_rvalid <= 1'b0;
      o_rdata <= 32'h0000_0000;
      o_rresp <= `FER_RESP_OKAY;
    end else if (o_rvalid) begin
      if (i_rready) begin
        o_rvalid <= 1'b0;
        o_arready <= 1'b1;
      end
    end else if (i_arvalid && o_arready) begin
      o_arready <= 1'b0;
      o_rvalid <= 1'b1;
      o_rdata <= reg_read({i_araddr[7:2], 2'h0});
      o_rresp <= reg_mapped({i_araddr[7:2], 2'h0}) ? `FER_RESP_OKAY : `FER_RESP_SLVERR;
    end else begin
      o_arready <= 1'b1;
    end
  end

endmodule // fill_ecc_error_recovery

// ==== dv/fill_ecc_chk.sv ====
// Port-level checker for the fill ECC error recovery block
`timescale 1ns/10ps
module fill_ecc_chk (
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  input wire fill_ecc_pkg::fill_event_type i_event,
  input wire logic i_scrub_done,
  input wire logic i_retry_done,
  input wire logic o_icache_bad_parity,
  input wire logic o_icache_flush,
  input wire logic o_dcache_write_raw,
  input wire logic o_victim_forward,
  input wire logic o_probe_forward,
  input wire logic o_load_hold,
  input wire logic o_replay_trap,
  input wire logic o_map_stall,
  input wire logic o_scrub_req,
  input wire logic o_load_retry,
  input wire logic o_machine_check_take
);
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_n);
  // Event qualifiers per source except victim miss, plus raw-write and victim-forward qualifiers
  wire ev_df = i_event.valid && i_event.kind == fill_ecc_pkg::EV_DFILL;
  wire ev_if = i_event.valid && i_event.kind == fill_ecc_pkg::EV_IFILL;
  wire ev_raw = ev_df && !i_event.load_use;
  wire ev_ve = i_event.valid && i_event.kind == fill_ecc_pkg::EV_VICTIM_EVICT;
  wire ev_fwd = ev_ve || (i_event.valid && i_event.kind == fill_ecc_pkg::EV_VICTIM_MISS);
  wire ev_pr = i_event.valid && i_event.kind == fill_ecc_pkg::EV_PROBE;
  sequence load_err_s;
    ev_df && i_event.load_use && !i_event.speculative && !o_load_hold;
  endsequence
  sequence trap_then_scrub_s;
    o_replay_trap && o_load_hold ##1 o_scrub_req;
  endsequence
  parity_on_ifill_a: assert property (ev_if |=> o_icache_bad_parity)
    else $error("no bad parity");
  flush_on_ifill_a: assert property (o_icache_flush == $past(ev_if))
    else $error("bad flush");
  machine_check_cause_a: assert property (o_machine_check_take |-> $past(ev_if))
    else $error("stray machine check");
  raw_write_a: assert property (o_dcache_write_raw == $past(ev_raw))
    else $error("bad raw write");
  replay_start_a: assert property (load_err_s |=> trap_then_scrub_s)
    else $error("no replay or scrub");
  stall_tie_a: assert property (o_map_stall == o_load_hold)
    else $error("stall and hold differ");
  scrub_end_a: assert property (o_scrub_req && i_scrub_done |=> !o_scrub_req && o_load_retry)
    else $error("no retry after scrub");
  retry_end_a: assert property (o_load_retry && i_retry_done |=> !o_load_retry && !o_load_hold)
    else $error("recovery not ended");
  spec_no_replay_a: assert property (ev_df && i_event.speculative |=> !o_replay_trap)
    else $error("speculative replay");
  victim_fwd_a: assert property (o_victim_forward == $past(ev_fwd))
    else $error("bad victim forward");
  evict_quiet_a: assert property (ev_ve |=> !o_machine_check_take && !o_replay_trap)
    else $error("evict raised exception");
  probe_fwd_a: assert property (o_probe_forward == $past(ev_pr))
    else $error("bad probe forward");
endmodule // fill_ecc_chk

bind fill_ecc_error_recovery fill_ecc_chk u_fill_ecc_chk (
  .i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_event(i_event),
  .i_scrub_done(i_scrub_done), .i_retry_done(i_retry_done),
  .o_icache_bad_parity(o_icache_bad_parity), .o_icache_flush(o_icache_flush),
  .o_dcache_write_raw(o_dcache_write_raw), .o_victim_forward(o_victim_forward),
  .o_probe_forward(o_probe_forward), .o_load_hold(o_load_hold),
  .o_replay_trap(o_replay_trap), .o_map_stall(o_map_stall), .o_scrub_req(o_scrub_req),
  .o_load_retry(o_load_retry), .o_machine_check_take(o_machine_check_take));

// ==== dv/fill_ecc_fabric.sv ====
// Behavioural cache fabric: raises error reports and answers recovery requests
`timescale 1ns/10ps
module fill_ecc_fabric (
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  input wire logic [3:0] i_delay,
  input wire logic i_scrub_req,
  input wire logic i_load_retry,
  output fill_ecc_pkg::fill_event_type o_event,
  output logic o_scrub_done,
  output logic o_retry_done
);
  logic [3:0] wait_reg;
  logic answered_reg;
  logic phase_reg;
  initial o_event = '0;
  // One error report, valid for exactly one cycle
  task automatic send(input fill_ecc_pkg::fill_event_type ev);
    @(posedge i_clk_sys);
    o_event <= ev;
    @(posedge i_clk_sys);
    o_event <= '0;
  endtask
  // Answer each request once after i_delay cycles; a phase change rearms it
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wait_reg <= 4'h0;
      answered_reg <= 1'h0;
      phase_reg <= 1'h0;
      o_scrub_done <= 1'h0;
      o_retry_done <= 1'h0;
    end else begin
      o_scrub_done <= 1'h0;
      o_retry_done <= 1'h0;
      if (i_scrub_req != phase_reg) begin
        phase_reg <= i_scrub_req;
        answered_reg <= 1'h0;
        wait_reg <= 4'h0;
      end else if ((i_scrub_req || i_load_retry) && !answered_reg) begin
        if (wait_reg == i_delay) begin
          o_scrub_done <= i_scrub_req;
          o_retry_done <= !i_scrub_req;
          answered_reg <= 1'h1;
        end else begin
          wait_reg <= wait_reg + 4'h1;
        end
      end
    end
  end
endmodule // fill_ecc_fabric

// ==== dv/fill_ecc_error_recovery_bench.sv ====
// Self-checking bench for the fill ECC error recovery block
`timescale 1ns/10ps
`include "fill_ecc_params.svh"
module fill_ecc_error_recovery_bench;
  logic i_clk_sys = 1'h0;
  logic i_rst_n = 1'h0;
  logic aw_valid = 1'h0, w_valid = 1'h0, b_ready = 1'h0, ar_valid = 1'h0, r_ready = 1'h0;
  logic [7:0] aw_addr = 8'h00, ar_addr = 8'h00;
  logic [31:0] w_data = 32'h0;
  logic [3:0] delay = 4'h0;
  fill_ecc_pkg::fill_event_type ev;
  logic scrub_done, retry_done, scrub_req, load_retry, load_hold, irq, machine_check;
  logic aw_ready, w_ready, b_valid, ar_ready, r_valid;
  logic [1:0] b_resp, r_resp;
  logic [31:0] r_data;
  logic [36:0] last_addr;
  int miscompares = 0, cmp_count = 0, cycles = 0;

  always #50 i_clk_sys = ~i_clk_sys;

  fill_ecc_error_recovery u_fill_ecc_error_recovery (
    .i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_event(ev), .i_scrub_done(scrub_done),
    .i_retry_done(retry_done), .o_icache_bad_parity(), .o_icache_flush(),
    .o_dcache_write_raw(), .o_victim_forward(), .o_probe_forward(), .o_load_hold(load_hold),
    .o_replay_trap(), .o_map_stall(), .o_scrub_req(scrub_req), .o_load_retry(load_retry),
    .o_machine_check_take(), .o_machine_check(machine_check), .o_irq(irq), .i_awaddr(aw_addr),
    .i_awvalid(aw_valid), .o_awready(aw_ready), .i_wdata(w_data), .i_wstrb(4'hF),
    .i_wvalid(w_valid), .o_wready(w_ready), .o_bresp(b_resp), .o_bvalid(b_valid),
    .i_bready(b_ready), .i_araddr(ar_addr), .i_arvalid(ar_valid), .o_arready(ar_ready),
    .o_rdata(r_data), .o_rresp(r_resp), .o_rvalid(r_valid), .i_rready(r_ready));

  fill_ecc_fabric u_fill_ecc_fabric (
    .i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_delay(delay), .i_scrub_req(scrub_req),
    .i_load_retry(load_retry), .o_event(ev), .o_scrub_done(scrub_done),
    .o_retry_done(retry_done));

  task automatic end_of_test;
    $display("Comparisons %0d, mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // A hung handshake would stall forever, so cycles are capped
  always @(posedge i_clk_sys) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      end_of_test();
    end
  end

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Bus write: address and data offered together, each dropped once taken
  task automatic axi_write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic aw_done, w_done;
    aw_done = 1'h0;
    w_done = 1'h0;
    @(posedge i_clk_sys);
    aw_addr <= a;
    w_data <= d;
    aw_valid <= 1'h1;
    w_valid <= 1'h1;
    b_ready <= 1'h1;
    while (!(aw_done && w_done)) begin
      @(posedge i_clk_sys);
      if (aw_valid && aw_ready) begin
        aw_done = 1'h1;
        aw_valid <= 1'h0;
      end
      if (w_valid && w_ready) begin
        w_done = 1'h1;
        w_valid <= 1'h0;
      end
    end
    while (!b_valid) @(posedge i_clk_sys);
    r = b_resp;
    b_ready <= 1'h0;
  endtask

  task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge i_clk_sys);
    ar_addr <= a;
    ar_valid <= 1'h1;
    r_ready <= 1'h1;
    @(posedge i_clk_sys);
    while (!ar_ready) @(posedge i_clk_sys);
    ar_valid <= 1'h0;
    @(posedge i_clk_sys);
    while (!r_valid) @(posedge i_clk_sys);
    d = r_data;
    r = r_resp;
    r_ready <= 1'h0;
  endtask

  task automatic put(input logic [7:0] a, input logic [31:0] d);
    logic [1:0] r;
    axi_write(a, d, r);
    check("write resp", {30'h0, r}, 32'h0);
  endtask

  task automatic reg_is(input string what, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] d;
    logic [1:0] r;
    axi_read(a, d, r);
    check(what, d, exp);
    check("read resp", {30'h0, r}, 32'h0);
  endtask

  // Code, address halves and both syndromes of the newest logged error
  task automatic log_is(input logic [2:0] code, input logic [36:0] a, input logic [15:0] syn);
    last_addr = a;
    reg_is("code", `FER_OFS_ERR_STATUS, {29'h0, code});
    reg_is("addr lo", `FER_OFS_ADDR_LO, a[31:0]);
    reg_is("addr hi", `FER_OFS_ADDR_HI, {27'h0, a[36:32]});
    reg_is("syndrome", `FER_OFS_SYNDROME, {16'h0, syn});
  endtask

  // Each case starts from cleared status
  task automatic clear_all;
    put(`FER_OFS_ERR_STATUS, 32'h0);
    put(`FER_OFS_DC_STATUS, 32'h1);
    put(`FER_OFS_INT_CLEAR, 32'h3);
  endtask

  // Kind codes: 0 ifill, 1 dfill, 2 victim on miss, 3 victim on evict, 4 probe
  task automatic fire(input logic [2:0] k, input logic m, input logic lu,
                      input logic sp, input logic [36:0] a, input logic [15:0] syn);
    u_fill_ecc_fabric.send('{1'h1, fill_ecc_pkg::event_kind_type'(k), m, lu, sp, a, syn[7:0],
                             syn[15:8]});
    repeat (2) @(posedge i_clk_sys);
  endtask

  task automatic t_regs;
    logic [31:0] d;
    logic [1:0] r;
    reg_is("enable", `FER_OFS_INT_ENABLE, 32'h0);
    reg_is("int status", `FER_OFS_INT_STATUS, 32'h0);
    axi_read(8'h20, d, r);
    check("unmapped data", d, 32'h0);
    check("unmapped resp", {30'h0, r}, 32'h2);
    axi_write(8'h24, 32'hFFFFFFFF, r);
    check("unmapped wresp", {30'h0, r}, 32'h2);
    put(`FER_OFS_INT_ENABLE, 32'h3);
    reg_is("enable", `FER_OFS_INT_ENABLE, 32'h3);
    $display("registers test done");
  endtask

  task automatic t_ifill;
    for (int m = 0; m < 2; m++) begin
      clear_all();
      fire(3'h0, m[0], 1'h0, 1'h0, 37'h1F000000A5 + m, 16'hC33C + m);
      log_is(m ? 3'h2 : 3'h1, 37'h1F000000A5 + m, 16'hC33C + m);
      reg_is("int status", `FER_OFS_INT_STATUS, 32'h3);
      check("irq", {31'h0, irq}, 32'h1);
      check("machine_check", {31'h0, machine_check}, 32'h1);
      put(`FER_OFS_INT_CLEAR, 32'h3);
      reg_is("int status", `FER_OFS_INT_STATUS, 32'h0);
      check("irq", {31'h0, irq}, 32'h0);
    end
    $display("instruction fill test done");
  endtask

  // Unused fill quadword, then load-used recovery prompt and slow
  task automatic t_dfill;
    int n;
    clear_all();
    fire(3'h1, 1'h0, 1'h0, 1'h0, 37'h0ABCDE0123, 16'h5A01);
    log_is(3'h3, 37'h0ABCDE0123, 16'h5A01);
    reg_is("int status", `FER_OFS_INT_STATUS, 32'h1);
    reg_is("load flag", `FER_OFS_DC_STATUS, 32'h0);
    for (int d = 0; d < 7; d += 6) begin
      delay <= d[3:0];
      clear_all();
      fire(3'h1, 1'h1, 1'h1, 1'h0, 37'h1000000040, 16'h0102);
      check("load hold", {31'h0, load_hold}, 32'h1);
      if (d != 0) begin
        fire(3'h1, 1'h0, 1'h1, 1'h0, 37'h0000000780, 16'h0304);
      end
      n = 0;
      while (load_hold && n < 100) begin
        @(posedge i_clk_sys);
        n++;
      end
      check("load hold", {31'h0, load_hold}, 32'h0);
      if (d != 0) begin
        log_is(3'h3, 37'h0000000780, 16'h0304);
      end else begin
        log_is(3'h4, 37'h1000000040, 16'h0102);
      end
      reg_is("load flag", `FER_OFS_DC_STATUS, 32'h1);
      reg_is("int status", `FER_OFS_INT_STATUS, 32'h1);
    end
    $display("data fill test done");
  endtask

  task automatic t_quiet;
    clear_all();
    fire(3'h1, 1'h0, 1'h1, 1'h1, 37'h1555555555, 16'h7777);
    check("load hold", {31'h0, load_hold}, 32'h0);
    reg_is("code", `FER_OFS_ERR_STATUS, 32'h0);
    reg_is("addr lo", `FER_OFS_ADDR_LO, last_addr[31:0]);
    reg_is("int status", `FER_OFS_INT_STATUS, 32'h1);
    clear_all();
    fire(3'h2, 1'h0, 1'h0, 1'h0, 37'h0123456789, 16'h9999);
    reg_is("code", `FER_OFS_ERR_STATUS, 32'h0);
    reg_is("addr lo", `FER_OFS_ADDR_LO, last_addr[31:0]);
    reg_is("int status", `FER_OFS_INT_STATUS, 32'h1);
    check("irq", {31'h0, irq}, 32'h1);
    clear_all();
    fire(3'h3, 1'h0, 1'h0, 1'h0, 37'h0123456789, 16'h9999);
    reg_is("int status", `FER_OFS_INT_STATUS, 32'h0);
    reg_is("code", `FER_OFS_ERR_STATUS, 32'h0);
    check("irq", {31'h0, irq}, 32'h0);
    $display("unlogged error test done");
  endtask

  task automatic t_probe_mask;
    clear_all();
    fire(3'h4, 1'h0, 1'h0, 1'h0, 37'h1FFFFFFFFF, 16'hFF00);
    log_is(3'h5, 37'h1FFFFFFFFF, 16'hFF00);
    reg_is("int status", `FER_OFS_INT_STATUS, 32'h1);
    put(`FER_OFS_INT_ENABLE, 32'h0);
    clear_all();
    fire(3'h0, 1'h0, 1'h0, 1'h0, 37'h0000000001, 16'h0001);
    reg_is("int status", `FER_OFS_INT_STATUS, 32'h3);
    check("irq", {31'h0, irq}, 32'h0);
    put(`FER_OFS_INT_ENABLE, 32'h1);
    reg_is("code", `FER_OFS_ERR_STATUS, 32'h1);
    check("irq", {31'h0, irq}, 32'h1);
    check("machine_check", {31'h0, machine_check}, 32'h0);
    $display("probe and mask test done");
  endtask

  // Reset, then the scenarios in turn
  initial begin
    repeat (4) @(posedge i_clk_sys);
    i_rst_n <= 1'h1;
    repeat (4) @(posedge i_clk_sys);
    t_regs();
    t_ifill();
    t_dfill();
    t_quiet();
    t_probe_mask();
    end_of_test();
  end
endmodule // fill_ecc_error_recovery_bench
